// ===== verilog/wfd_pkg.sv
/*
 * wfd_pkg: constants and types shared by the wake frame detector.
 * Assumes a byte-wide receive stream on the system clock.
 */
package wfd_pkg;

   // sync stream and address-repeat sequence
   localparam logic [7:0] WFD_SYNC_BYTE   = 8'hFF;
   localparam int         WFD_SYNC_LEN    = 6;
   localparam int         WFD_ADDR_BYTES  = 6;
   localparam int         WFD_ADDR_COPIES = 16;
   localparam int         WFD_PASS_BYTES  = 6;

   // frame layout
   localparam int WFD_DA_POS       = 0;
   localparam int WFD_MIN_FRAME    = 18;
   localparam int WFD_PATTERN_LEN  = 64;
   localparam int WFD_POS_W        = 8;

   // wake event output modes
   localparam logic [1:0] WFD_EV_PULSE = 2'h0;
   localparam logic [1:0] WFD_EV_LEVEL = 2'h1;
   localparam logic [1:0] WFD_EV_FLAG  = 2'h2;

   // wake pulse length on the event pin
   localparam int WFD_PULSE_NS     = 64;
   localparam int WFD_CLK_PERIOD_NS = 8;
   localparam int WFD_PULSE_CYCLES =
      (WFD_PULSE_NS + WFD_CLK_PERIOD_NS - 1) / WFD_CLK_PERIOD_NS;

   // reset values
   localparam logic [7:0] WFD_CNT_RST = 8'h00;

   // sequence matcher phases, one-hot
   typedef enum logic [3:0] {
      WFD_PH_SYNC = 4'h1,
      WFD_PH_ADDR = 4'h2,
      WFD_PH_PASS = 4'h4,
      WFD_PH_DONE = 4'h8
   } wfd_phase_t;

endpackage

// ===== verilog/wfd_seq_matcher.sv
/*
 * wfd_seq_matcher: scans a byte stream for six sync bytes, sixteen
 * copies of the station address and an optional password.
 * Assumes the caller restarts it at each frame start.
 */
`timescale 1ns/1ps
`default_nettype none

module wfd_seq_matcher
   import wfd_pkg::*;
(
   input  wire logic            i_clk_sys,
   input  wire logic            i_reset,
   input  wire logic            i_ce,
   input  wire logic            i_restart,
   input  wire logic            i_byte_valid,
   input  wire logic [7:0]      i_byte,
   input  wire logic [5:0][7:0] i_addr,
   input  wire logic            i_pass_en,
   input  wire logic [5:0][7:0] i_pass,
   output logic                 o_hit
);

   typedef struct packed {
      wfd_phase_t phase;
      logic [2:0] sync_cnt;
      logic [2:0] idx;
      logic [3:0] copy;
      logic       hit;
   } wfd_seq_t;

   wfd_seq_t s_reg;
   wfd_seq_t s_next;
   logic     is_sync;
   logic     addr_eq;
   logic     pass_eq;

   assign is_sync = (i_byte == WFD_SYNC_BYTE);
   assign addr_eq = (i_byte == i_addr[s_reg.idx]);
   assign pass_eq = (i_byte == i_pass[s_reg.idx]);

   // next state of the scanner, one byte per valid cycle
   always_comb begin
      s_next = s_reg;
      if (i_restart) begin
         s_next.phase    = WFD_PH_SYNC;
         s_next.sync_cnt = 3'h0;
         s_next.idx      = 3'h0;
         s_next.copy     = 4'h0;
         s_next.hit      = 1'b0;
      end else if (i_byte_valid) begin
         case (s_reg.phase)
            WFD_PH_SYNC: begin
               if (!is_sync) begin
                  s_next.sync_cnt = 3'h0;
               end else if (s_reg.sync_cnt == 3'(WFD_SYNC_LEN - 1)) begin
                  s_next.phase = WFD_PH_ADDR;
                  s_next.idx   = 3'h0;
                  s_next.copy  = 4'h0;
               end else begin
                  s_next.sync_cnt = s_reg.sync_cnt + 3'h1;
               end
            end
            WFD_PH_ADDR: begin
               if (addr_eq) begin
                  if (s_reg.idx == 3'(WFD_ADDR_BYTES - 1)) begin
                     s_next.idx = 3'h0;
                     if (s_reg.copy == 4'(WFD_ADDR_COPIES - 1)) begin
                        s_next.phase = i_pass_en ? WFD_PH_PASS
                                                 : WFD_PH_DONE;
                        s_next.hit   = !i_pass_en;
                     end else begin
                        s_next.copy = s_reg.copy + 4'h1;
                     end
                  end else begin
                     s_next.idx = s_reg.idx + 3'h1;
                  end
               end else if (is_sync && s_reg.idx == 3'h0 &&
                            s_reg.copy == 4'h0) begin
                  // extra sync bytes keep the stream primed
                  s_next.phase = WFD_PH_ADDR;
               end else begin
                  s_next.phase    = WFD_PH_SYNC;
                  s_next.sync_cnt = is_sync ? 3'h1 : 3'h0;
               end
            end
            WFD_PH_PASS: begin
               if (pass_eq) begin
                  if (s_reg.idx == 3'(WFD_PASS_BYTES - 1)) begin
                     s_next.phase = WFD_PH_DONE;
                     s_next.hit   = 1'b1;
                  end else begin
                     s_next.idx = s_reg.idx + 3'h1;
                  end
               end else begin
                  s_next.phase    = WFD_PH_SYNC;
                  s_next.sync_cnt = is_sync ? 3'h1 : 3'h0;
               end
            end
            WFD_PH_DONE: begin
               s_next.hit = 1'b1; // hold until next frame
            end
            default: begin
               s_next.phase = WFD_PH_SYNC;
            end
         endcase
      end
   end

   // state register, frozen while clock enable is low
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         s_reg.phase    <= WFD_PH_SYNC;
         s_reg.sync_cnt <= 3'h0;
         s_reg.idx      <= 3'h0;
         s_reg.copy     <= 4'h0;
         s_reg.hit      <= 1'b0;
      end else if (i_ce) begin
         s_reg <= s_next;
      end
   end

   assign o_hit = s_reg.hit;

endmodule

`default_nettype wire

// ===== verilog/wfd_detector.sv
/*
 * wfd_detector: wake frame detection on the receive byte stream.
 * Checks destination, length, address-repeat sequence, password and
 * a masked 64-byte custom pattern, gates on a good CRC and signals a
 * wake event on a pin or a sticky flag.
 * Configuration and status are plain ports; the management side
 * keeps the receive configuration, receive status and interrupt
 * words and wires their bits here.
 * Assumes a byte stream already aligned and decoded by the receive
 * path on the system clock, with frame-end CRC verdict supplied.
 * Assumes start, byte and end strobes are one cycle each and never
 * fall in one cycle; a start strobe restarts the frame.
 * Assumes the CRC bytes are counted into the frame, so the length
 * check includes them.
 * Slower lines only leave gaps between byte strobes; nothing here
 * depends on the spacing.
 * Limitation: bytes consumed by a broken run are not scanned again;
 * only the byte that broke it starts the next search.
 * Limitation: the custom pattern is compared from the first
 * destination byte, so frames shorter than it never match.
 * Trade-off: one byte per cycle at most; a line faster than the
 * system clock would need a wider datapath.
 */
`timescale 1ns/1ps
`default_nettype none

module wfd_detector
   import wfd_pkg::*;
#(
   parameter int PULSE_CYCLES = WFD_PULSE_CYCLES,
   parameter int PATTERN_LEN  = WFD_PATTERN_LEN,
   parameter int MIN_FRAME    = WFD_MIN_FRAME
)
(
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_reset,
   input  wire logic                       i_ce,
   // receive byte stream
   input  wire logic                       i_rx_sof,
   input  wire logic                       i_rx_valid,
   input  wire logic [7:0]                 i_rx_byte,
   input  wire logic                       i_rx_eof,
   input  wire logic                       i_rx_crc_ok,
   // receive frame configuration
   input  wire logic                       i_detect_en,
   input  wire logic                       i_bcast_en,
   input  wire logic                       i_pass_en,
   input  wire logic                       i_pattern_en,
   input  wire logic [1:0]                 i_event_mode,
   input  wire logic [5:0][7:0]            i_station_addr,
   input  wire logic [5:0][7:0]            i_password,
   // custom pattern and its byte mask
   input  wire logic [PATTERN_LEN-1:0][7:0] i_pattern,
   input  wire logic [PATTERN_LEN-1:0]     i_pattern_mask,
   // sticky status clear
   input  wire logic                       i_status_clear,
   // second interrupt status: enable and clear
   input  wire logic                       i_flag_en,
   input  wire logic                       i_flag_clear,
   // outputs
   output logic                            o_wake_pin,
   output logic                            o_wake_flag,
   // wake frame status, sticky until cleared
   output logic                            o_status_seq,
   output logic                            o_status_pass,
   output logic                            o_status_pattern,
   output logic                            o_status_crc_drop
);

   typedef struct packed {
      // frame tracking, destination and pattern verdicts
      logic [WFD_POS_W-1:0] pos;
      logic                 in_frame;
      logic                 da_own;
      logic                 da_bcast;
      logic                 pat_ok;
      // wake event outputs
      logic [7:0]           pulse_cnt;
      logic                 wake_pin;
      logic                 wake_flag;
      // sticky status
      logic                 st_seq;
      logic                 st_pass;
      logic                 st_pattern;
      logic                 st_crc_drop;
   } wfd_top_t;

   wfd_top_t t_reg;
   wfd_top_t t_next;

   logic       seq_hit;
   logic       da_byte;
   logic [2:0] da_idx;
   logic       frame_end;
   logic       addr_ok;
   logic       len_ok;
   logic       pat_hit;
   logic       matched;
   logic       wake_ok;
   logic       crc_drop;
   logic       pat_byte_ok;

   // wake terms per type and the decoded event mode
   logic       seq_wake;
   logic       pass_wake;
   logic       pat_wake;
   logic       ev_level;

   // the scanner restarts on every start strobe, even mid-frame
   // sequence scanner on the byte stream
   wfd_seq_matcher u_seq (
      .i_clk_sys    (i_clk_sys),
      .i_reset      (i_reset),
      .i_ce         (i_ce),
      .i_restart    (i_rx_sof),
      .i_byte_valid (i_rx_valid & t_reg.in_frame),
      .i_byte       (i_rx_byte),
      .i_addr       (i_station_addr),
      .i_pass_en    (i_pass_en),
      .i_pass       (i_password),
      .o_hit        (seq_hit)
   );

   // destination field: first six bytes of the frame
   // broadcast is all ones, the same value as a sync byte
   assign da_byte = i_rx_valid && t_reg.in_frame &&
                    (t_reg.pos < WFD_POS_W'(WFD_DA_POS + WFD_ADDR_BYTES));
   assign da_idx  = t_reg.pos[2:0];

   // custom pattern byte check, bytes with a clear mask bit always pass
   // bytes past the pattern length never spoil it
   assign pat_byte_ok = (t_reg.pos >= WFD_POS_W'(PATTERN_LEN)) ||
                        !i_pattern_mask[t_reg.pos[5:0]] ||
                        (i_rx_byte == i_pattern[t_reg.pos[5:0]]);

   // frame verdict terms, valid when frame_end is high
   // they read the position, which the end strobe leaves unchanged
   assign frame_end = i_rx_eof && t_reg.in_frame;
   assign addr_ok   = t_reg.da_own || (i_bcast_en && t_reg.da_bcast);
   // position saturates, so long frames keep passing
   // room for both addresses and CRC
   assign len_ok    = t_reg.pos >= WFD_POS_W'(MIN_FRAME);
   // pattern type needs all 64 bytes seen
   assign pat_hit   = i_pattern_en && t_reg.pat_ok &&
                      (t_reg.pos >= WFD_POS_W'(PATTERN_LEN));
   assign matched   = i_detect_en && addr_ok && len_ok &&
                      (seq_hit || pat_hit);
   assign wake_ok   = frame_end && matched && i_rx_crc_ok;
   assign crc_drop  = frame_end && matched && !i_rx_crc_ok;

   // per-type wake terms for the sticky status bits
   assign seq_wake  = wake_ok && seq_hit;
   assign pass_wake = seq_wake && i_pass_en;
   assign pat_wake  = wake_ok && pat_hit;

   // level mode is the only one whose pin a flag clear drops
   assign ev_level  = (i_event_mode == WFD_EV_LEVEL);

   // frame tracking, status and event generation
   always_comb begin
      // every field holds unless a branch below moves it
      t_next = t_reg;

      // a start strobe mid-frame simply restarts tracking
      // speed independent byte stream
      if (i_rx_sof) begin
         t_next.in_frame = 1'b1;
         t_next.pos      = WFD_POS_W'(0);
         t_next.da_own   = 1'b1;
         t_next.da_bcast = 1'b1;
         t_next.pat_ok   = 1'b1;
      end else if (frame_end) begin
         // the verdict terms still see the old position
         t_next.in_frame = 1'b0;
      end else if (i_rx_valid && t_reg.in_frame) begin
         // position saturates; only its low range matters
         if (t_reg.pos != {WFD_POS_W{1'b1}}) begin
            t_next.pos = t_reg.pos + WFD_POS_W'(1);
         end
         if (da_byte) begin
            if (i_rx_byte != i_station_addr[da_idx]) begin
               t_next.da_own = 1'b0;
            end
            if (i_rx_byte != WFD_SYNC_BYTE) begin
               t_next.da_bcast = 1'b0;
            end
         end
         if (!pat_byte_ok) begin
            t_next.pat_ok = 1'b0;
         end
      end

      // status clears, a new event wins
      if (i_status_clear) begin
         t_next.st_seq      = 1'b0;
         t_next.st_pass     = 1'b0;
         t_next.st_pattern  = 1'b0;
         t_next.st_crc_drop = 1'b0;
      end
      // sets follow the clear, so an event in the clear cycle stays
      if (seq_wake) begin
         t_next.st_seq = 1'b1;
      end
      if (pass_wake) begin
         t_next.st_pass = 1'b1;
      end
      if (pat_wake) begin
         t_next.st_pattern = 1'b1;
      end
      // only frames that matched can be dropped
      // record suppressed frames
      if (crc_drop) begin
         t_next.st_crc_drop = 1'b1;
      end

      // a new event reloads the count and stretches the pulse
      // pulse mode countdown
      if (t_reg.pulse_cnt != 8'h00) begin
         t_next.pulse_cnt = t_reg.pulse_cnt - 8'h01;
         t_next.wake_pin  = (t_reg.pulse_cnt != 8'h01);
      end
      if (i_flag_clear) begin
         t_next.wake_flag = 1'b0;
      end
      // a mode change before the clear leaves a level pin standing
      if (i_flag_clear && ev_level) begin
         t_next.wake_pin = 1'b0; // level also returns on clear
      end

      if (wake_ok) begin
         case (i_event_mode)
            WFD_EV_PULSE: begin
               // reload to the full pulse length
               t_next.wake_pin  = 1'b1;
               t_next.pulse_cnt = 8'(PULSE_CYCLES);
            end
            WFD_EV_LEVEL: begin
               // stands until a flag clear
               t_next.wake_pin = 1'b1;
            end
            WFD_EV_FLAG: begin
               if (i_flag_en) begin
                  t_next.wake_flag = 1'b1;
               end
            end
            default: begin
               // mode 3 records status only
               t_next.wake_flag = t_next.wake_flag;
            end
         endcase
      end
   end

   // state register, frozen while clock enable is low
   // reset acts even with the enable low
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         t_reg.pos         <= WFD_CNT_RST;
         t_reg.in_frame    <= 1'b0;
         t_reg.da_own      <= 1'b0;
         t_reg.da_bcast    <= 1'b0;
         t_reg.pat_ok      <= 1'b0;
         t_reg.pulse_cnt   <= WFD_CNT_RST;
         t_reg.wake_pin    <= 1'b0;
         t_reg.wake_flag   <= 1'b0;
         t_reg.st_seq      <= 1'b0;
         t_reg.st_pass     <= 1'b0;
         t_reg.st_pattern  <= 1'b0;
         t_reg.st_crc_drop <= 1'b0;
      end else if (i_ce) begin
         t_reg <= t_next;
      end
   end

   // all outputs straight from the state register
   assign o_wake_pin        = t_reg.wake_pin;
   assign o_wake_flag       = t_reg.wake_flag;
   assign o_status_seq      = t_reg.st_seq;
   assign o_status_pass     = t_reg.st_pass;
   assign o_status_pattern  = t_reg.st_pattern;
   assign o_status_crc_drop = t_reg.st_crc_drop;

endmodule

`default_nettype wire

// ===== verification/wfd_chk.sv
/* wfd_chk: port assertions for the wake frame detector.
   Assumes a single clock domain; clears count only with i_ce high. */
`timescale 1ns/1ps
`default_nettype none
module wfd_chk
   import wfd_pkg::*;
#(
   parameter int PULSE_CYCLES = WFD_PULSE_CYCLES
)
(
   input wire logic       i_clk_sys,
   input wire logic       i_reset,
   input wire logic       i_ce,
   input wire logic       i_rx_eof,
   input wire logic       i_rx_crc_ok,
   input wire logic       i_detect_en,
   input wire logic       i_pass_en,
   input wire logic [1:0] i_event_mode,
   input wire logic       i_status_clear,
   input wire logic       i_flag_en,
   input wire logic       i_flag_clear,
   input wire logic       o_wake_pin,
   input wire logic       o_wake_flag,
   input wire logic       o_status_seq,
   input wire logic       o_status_pass,
   input wire logic       o_status_pattern,
   input wire logic       o_status_crc_drop
);
   logic [8:0] hi_cnt_reg;
   logic       any_st;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // status bits as one group
   assign any_st = o_status_seq | o_status_pass | o_status_pattern
                 | o_status_crc_drop;
   // high run of the pin; level runs may wrap, only pulses are judged
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !o_wake_pin) begin
         hi_cnt_reg <= 9'h000;
      end else begin
         hi_cnt_reg <= hi_cnt_reg + 9'h001;
      end
   end
   AST_RST_QUIET: assert property ($fell(i_reset) |-> !any_st)
      else $error("status set right after reset");
   AST_SEQ_CAUSE: assert property ($rose(o_status_seq) |->
      $past(i_rx_eof && i_rx_crc_ok && i_detect_en))
      else $error("sequence status without good frame end");
   AST_DROP_CAUSE: assert property ($rose(o_status_crc_drop) |->
      $past(i_rx_eof && !i_rx_crc_ok))
      else $error("drop status without bad crc");
   AST_DROP_QUIET: assert property ($rose(o_status_crc_drop) |->
      !$rose(o_wake_pin) && !$rose(o_wake_flag))
      else $error("wake event on bad crc frame");
   AST_PASS_SEQ: assert property ($rose(o_status_pass) |->
      o_status_seq && $past(i_pass_en))
      else $error("password status without sequence");
   AST_FLAG_SRC: assert property ($rose(o_wake_flag) |->
      $past(i_event_mode == WFD_EV_FLAG && i_flag_en && i_rx_eof))
      else $error("wake flag set without cause");
   AST_PULSE_LEN: assert property ($fell(o_wake_pin) &&
      i_event_mode == WFD_EV_PULSE |-> int'(hi_cnt_reg) == PULSE_CYCLES)
      else $error("wake pulse length wrong");
   AST_LEVEL_HOLD: assert property (i_event_mode == WFD_EV_LEVEL &&
      o_wake_pin && !i_flag_clear |=> o_wake_pin)
      else $error("level event dropped early");
   AST_FLAG_CLR: assert property (i_ce && i_flag_clear && !i_rx_eof |=>
      !o_wake_flag)
      else $error("wake flag not cleared");
   AST_STAT_CLR: assert property (i_ce && i_status_clear &&
      !i_rx_eof |=> !any_st)
      else $error("status not cleared");
endmodule
bind wfd_detector wfd_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce),
   .i_rx_eof(i_rx_eof),
   .i_rx_crc_ok(i_rx_crc_ok), .i_detect_en(i_detect_en),
   .i_pass_en(i_pass_en), .i_event_mode(i_event_mode),
   .i_status_clear(i_status_clear), .i_flag_en(i_flag_en),
   .i_flag_clear(i_flag_clear), .o_wake_pin(o_wake_pin),
   .o_wake_flag(o_wake_flag), .o_status_seq(o_status_seq),
   .o_status_pass(o_status_pass), .o_status_pattern(o_status_pattern),
   .o_status_crc_drop(o_status_crc_drop)
);
`default_nettype wire

// ===== verification/wfd_link_model.sv
/* wfd_link_model: remote station sending frames as a byte stream.
   Assumes the bench fills frm before calling send. */
`timescale 1ns/1ps
`default_nettype none
module wfd_link_model (
   input  wire logic       i_clk_sys,
   output logic            o_sof,
   output logic            o_valid,
   output logic [7:0]      o_byte,
   output logic            o_eof,
   output logic            o_crc_ok
);
   logic [7:0] frm [0:255];
   // idle line state at time zero
   initial begin
      {o_sof, o_valid, o_eof, o_crc_ok} = 4'h0;
      o_byte = 8'h00;
   end
   // slow mode stalls one cycle after every other byte, leaving gaps as a slower line would
   task automatic send(input int len, input logic ok, input logic slow);
      @(posedge i_clk_sys);
      o_sof <= 1'b1;
      for (int i = 0; i < len; i++) begin
         @(posedge i_clk_sys);
         o_sof   <= 1'b0;
         o_valid <= 1'b1;
         o_byte  <= frm[i];
         if (slow && i[0]) begin
            @(posedge i_clk_sys);
            o_valid <= 1'b0;
            o_byte  <= ~frm[i];
         end
      end
      @(posedge i_clk_sys);
      o_valid  <= 1'b0;
      o_byte   <= ~frm[len-1];
      o_eof    <= 1'b1;
      o_crc_ok <= ok;
      @(posedge i_clk_sys);
      o_eof    <= 1'b0;
      o_crc_ok <= ~ok;
   endtask
endmodule
`default_nettype wire

// ===== verification/test_wfd_detector.sv
/* test_wfd_detector: random wake frames against the detector.
   Assumes the link model and bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module test_wfd_detector;
   import wfd_pkg::*;
   logic            i_clk_sys, i_reset, i_ce, i_detect_en, i_bcast_en;
   logic            i_pass_en, i_pattern_en, i_status_clear, i_flag_en;
   logic            i_flag_clear;
   logic [1:0]      i_event_mode;
   logic [5:0][7:0] i_station_addr, i_password;
   logic [63:0][7:0] i_pattern;
   logic [63:0]     i_pattern_mask;
   wire logic       sof, valid, eof, crc_ok, pin, flag;
   wire logic       s_seq, s_pass, s_pat, s_drop;
   wire logic [7:0] rx_byte;
   integer          seed = 32'h1C3C;
   int              error_cnt = 0;
   int              n_tests = 0;
   int              p;
   wfd_link_model link (.i_clk_sys(i_clk_sys), .o_sof(sof),
      .o_valid(valid), .o_byte(rx_byte), .o_eof(eof), .o_crc_ok(crc_ok));
   wfd_detector DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce),
      .i_rx_sof(sof), .i_rx_valid(valid), .i_rx_byte(rx_byte),
      .i_rx_eof(eof), .i_rx_crc_ok(crc_ok), .i_detect_en(i_detect_en),
      .i_bcast_en(i_bcast_en), .i_pass_en(i_pass_en),
      .i_pattern_en(i_pattern_en), .i_event_mode(i_event_mode),
      .i_station_addr(i_station_addr), .i_password(i_password),
      .i_pattern(i_pattern), .i_pattern_mask(i_pattern_mask),
      .i_status_clear(i_status_clear), .i_flag_en(i_flag_en),
      .i_flag_clear(i_flag_clear), .o_wake_pin(pin), .o_wake_flag(flag),
      .o_status_seq(s_seq), .o_status_pass(s_pass),
      .o_status_pattern(s_pat), .o_status_crc_drop(s_drop));
   // 125 MHz system clock
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("mismatches=%0d compares=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // status {seq, pass, pattern, drop}
   function automatic logic [3:0] st_exp(input logic sq, input logic pe,
                                         input logic pm, input logic ok);
      st_exp = {ok & sq, ok & sq & pe, ok & pm, !ok & (sq | pm)};
   endfunction
   // event {pin, flag}; mode 3 gives neither
   function automatic logic [1:0] ev_exp(input logic w, input logic [1:0] md,
                                         input logic fe);
      ev_exp = {w && md != WFD_EV_FLAG && md != 2'h3,
                w && md == WFD_EV_FLAG && fe};
   endfunction
   task automatic put(input logic [7:0] b);
      link.frm[p] = b;
      p++;
   endtask
   task automatic put_seq(input logic [5:0][7:0] a, input int c);
      repeat (6) put(WFD_SYNC_BYTE);
      for (int i = 0; i < c * 6; i++) put(a[i % 6]);
   endtask
   // a hang ends the run as a failure
   initial begin
      #600000;
      error_cnt++;
      complete_run();
   end
   initial begin
      int dt, ins, k;
      logic det, bc, pe, pt, fe, ok, slow, seq_ok, pat_ok;
      logic [1:0] md;
      logic [3:0] st;
      logic [1:0] ev;
      logic [5:0][7:0] sa, pw, da;
      logic [63:0][7:0] pat;
      logic [63:0] msk;
      {i_reset, i_ce, i_status_clear, i_flag_clear} = 4'hC;
      {i_detect_en, i_bcast_en, i_pass_en, i_pattern_en} = 4'h0;
      i_flag_en = 1'b0;
      i_event_mode = 2'h0;
      i_station_addr = 48'h0;
      i_password = 48'h0;
      i_pattern = '0;
      i_pattern_mask = 64'h0;
      repeat (12) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      for (int n = 0; n < 80; n++) begin
         {det, bc, pe, pt, fe, slow} = 6'($random(seed));
         det = det | n[0];
         md = 2'(n);
         ok = ($random(seed) & 3) != 0;
         sa = 48'({$random(seed), $random(seed)});
         sa[0][0] = 1'b0;
         pw = 48'({$random(seed), $random(seed)});
         dt = {$random(seed)} % 3;
         da = (dt == 0) ? sa : (dt == 1) ? 48'hFFFFFFFFFFFF : sa ^ 48'h1;
         p = 0;
         for (int j = 0; j < 6; j++) put(da[j]);
         repeat (8 + {$random(seed)} % 8) put(8'($random(seed)));
         ins = {$random(seed)} % 4;
         seq_ok = (ins == 1 || ins == 2) && (dt == 0 || (dt == 1 && bc));
         if (ins == 2) put_seq(sa, 5);
         if (ins != 0) put_seq(sa, (ins == 3 && !pe) ? 15 : 16);
         if (ins == 3 && !pe) put(sa[0] ^ 8'h01);
         for (int j = 0; j < 6 && ins != 0 && pe; j++)
            put(pw[j] ^ {7'h00, ins == 3 && j == 0});
         repeat ({$random(seed)} % 48 + 4) put(8'($random(seed)));
         for (int j = 0; j < 64; j++) pat[j] = link.frm[j];
         k = {$random(seed)} % 64;
         pat[k] = pat[k] ^ 8'h01;
         msk = {$random(seed), $random(seed)};
         pat_ok = p >= 64 && !msk[k] && (dt == 0 || (dt == 1 && bc));
         @(posedge i_clk_sys);
         {i_status_clear, i_flag_clear} <= 2'h3;
         // clear under the old mode so a level pin drops, then reload
         @(posedge i_clk_sys);
         {i_status_clear, i_flag_clear} <= 2'h0;
         {i_detect_en, i_bcast_en, i_pass_en} <= {det, bc, pe};
         {i_pattern_en, i_flag_en, i_event_mode} <= {pt, fe, md};
         i_station_addr <= sa;
         i_password <= pw;
         i_pattern <= pat;
         i_pattern_mask <= msk;
         @(posedge i_clk_sys);
         #1 chk({pin, flag, s_seq, s_pass, s_pat, s_drop}, 8'h00);
         link.send(p, ok, slow); // stalls
         #1 st = st_exp(det & seq_ok, pe, det & pt & pat_ok, ok);
         chk({s_seq, s_pass, s_pat, s_drop}, st);
         ev = ev_exp(st[3] | st[1], md, fe);
         chk({pin, flag}, ev);
         if (md == WFD_EV_PULSE && (st[3] | st[1])) begin
            repeat (7) @(posedge i_clk_sys);
            #1 chk(pin, 8'h01);
            @(posedge i_clk_sys);
            #1 chk(pin, 8'h00);
         end
         // clears with the enable low must leave every output alone
         @(posedge i_clk_sys);
         {i_ce, i_status_clear, i_flag_clear} <= 3'h3;
         @(posedge i_clk_sys);
         {i_ce, i_status_clear, i_flag_clear} <= 3'h4;
         #1 chk({pin, flag, s_seq, s_pass, s_pat, s_drop},
                {ev[1] & (md != WFD_EV_PULSE), ev[0], st});
      end
      complete_run();
   end
endmodule
`default_nettype wire
